// ===== hw/sbp_packer.sv
// serial byte packer: buffers serial bytes and releases them as frames
// Behaviour
// - length limit zero means no maximum; release on marker, full or timeout
// - nonzero length limit releases the frame when the count equals it
// - with no marker configured every byte leaves at once
// - with markers configured bytes accumulate until the marker is seen
// - second marker zero is single marking; both zero disable marking
// - a full 1K buffer is released as a frame and emptied
// - marker matching and post action need the first marker enabled
// - with two markers, first must be directly followed by the second
// - plain mode releases the buffer including the marker on recognition
// - plus-one and plus-two modes release after one or two more bytes
// - strip mode drops marker bytes and releases only preceding bytes
// - idle timeout of zero disables timeout release
// - nonzero idle timeout releases all bytes when no byte arrives in time
// - session timer works only when opening on any received character
// - nonzero inactivity time requests session closure; zero disables it
`timescale 1ns/1ps
`default_nettype none
module sbp_packer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [sbp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial side
  input wire logic ser_valid,
  input wire logic [7:0] ser_data,
  output logic ser_ready,
  input wire logic ser_tx_act,
  input wire logic ms_tick,
  // frame stream toward the network
  output logic frm_valid,
  output logic [7:0] frm_data,
  output logic frm_last,
  input wire logic frm_ready,
  // session control
  output logic session_close_req
);
  import sbp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  sbp_state_type state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] flen_ff;
  logic [CNT_W-1:0] rd_ff;
  logic [CNT_W-1:0] nxt_rd;
  logic [1:0] post_ff;
  logic prev_d1_ff;
  logic [7:0] out_ff;
  logic [7:0] buf_ff [0:BUF_DEPTH-1];
  logic [15:0] frames_ff;
  logic take;
  logic mark_en;
  logic two;
  logic hit1;
  logic mark_hit;
  logic strip;
  logic [CNT_W-1:0] new_cnt;
  logic [CNT_W-1:0] strip_len;
  logic rel_byte;
  logic [CNT_W-1:0] rel_len;
  logic rel_idle;
  logic flush;
  logic go_drain;
  logic drain_end;
  logic idle_exp;
  logic sess_exp;

  sbp_cfg_if cfg ();

  ////////////////////////////////////////////////////////////////////////
  // register file and timers

  // register file on the bus
  sbp_regs u_regs (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg(cfg)
  );

  // idle release timer, only while bytes wait
  sbp_ms_timer u_idle (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(ms_tick),
    .run((state_ff == ST_COLLECT) && (cnt_ff != '0)),
    .restart(take),
    .limit(cfg.force_ms),
    .expire(idle_exp)
  );

  // session inactivity timer, traffic in either direction restarts it
  sbp_ms_timer u_sess (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(ms_tick),
    .run(cfg.trigger_any),
    .restart(ser_valid || ser_tx_act),
    .limit(cfg.inact_ms),
    .expire(sess_exp)
  );

  // status toward the register file
  assign cfg.buf_cnt = cnt_ff;
  assign cfg.draining = (state_ff == ST_DRAIN);
  assign cfg.frames = frames_ff;
  assign cfg.close_set = sess_exp;
  assign session_close_req = cfg.close_req;

  ////////////////////////////////////////////////////////////////////////
  // byte intake and marker matching

  // bytes are taken only while collecting
  assign ser_ready = (state_ff == ST_COLLECT);
  assign take = ser_valid && ser_ready;

  // marking needs the first marker; second zero means single character
  assign mark_en = (cfg.delim1 != 8'h00);
  assign two = (cfg.delim2 != 8'h00);
  assign hit1 = (ser_data == cfg.delim1);
  assign mark_hit = mark_en && (post_ff == 2'h0) &&
                    (two ? (prev_d1_ff && (ser_data == cfg.delim2)) : hit1);
  assign strip = mark_hit && (cfg.proc_mode == PROC_STRIP);
  assign new_cnt = cnt_ff + 11'h001;
  // in strip mode the held first marker is dropped too
  assign strip_len = (two && (cnt_ff != '0)) ? (cnt_ff - 11'h001) : cnt_ff;

  // release decision for the byte being taken, one winner only
  always_comb begin
    rel_byte = 1'b0;
    rel_len = new_cnt;
    if (take) begin
      if (strip) begin
        rel_byte = 1'b1;
        rel_len = strip_len;
      end else if (!mark_en) begin
        rel_byte = 1'b1;
      end else if (mark_hit && (cfg.proc_mode == PROC_PLAIN)) begin
        rel_byte = 1'b1;
      end else if (post_ff == 2'h1) begin
        rel_byte = 1'b1;
      end else if ((cfg.pkt_len != '0) && (new_cnt == cfg.pkt_len)) begin
        rel_byte = 1'b1;
      end else if (new_cnt == BUF_FULL) begin
        rel_byte = 1'b1;
      end
    end
  end

  // idle timeout releases whatever is held
  assign rel_idle = idle_exp && !take && (cnt_ff != '0) && (state_ff == ST_COLLECT);
  assign flush = rel_byte || rel_idle;
  // a stripped marker alone yields no frame
  assign go_drain = (rel_byte && (rel_len != '0)) || rel_idle;

  ////////////////////////////////////////////////////////////////////////
  // collection state

  // buffer storage, the byte completing a marker match skipped in strip mode
  always_ff @(posedge ref_clk) begin
    if (take && !strip) begin
      buf_ff[cnt_ff[9:0]] <= ser_data;
    end
  end

  // byte count, zero after every release
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (flush) begin
      cnt_ff <= '0;
    end else if (take) begin
      cnt_ff <= new_cnt;
    end
  end

  // bytes still owed after a marker in plus modes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      post_ff <= 2'h0;
    end else if (flush) begin
      post_ff <= 2'h0;
    end else if (take) begin
      if (post_ff != 2'h0) begin
        post_ff <= post_ff - 2'h1;
      end else if (mark_hit && (cfg.proc_mode == PROC_PLUS1)) begin
        post_ff <= 2'h1;
      end else if (mark_hit && (cfg.proc_mode == PROC_PLUS2)) begin
        post_ff <= 2'h2;
      end
    end
  end

  // previous byte was the first marker, never across frames
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_d1_ff <= 1'b0;
    end else if (flush) begin
      prev_d1_ff <= 1'b0;
    end else if (take) begin
      prev_d1_ff <= hit1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame drain

  // packer state and frame length
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_COLLECT;
      flen_ff <= '0;
    end else begin
      case (state_ff)
        ST_COLLECT: begin
          if (go_drain) begin
            state_ff <= ST_DRAIN;
            flen_ff <= rel_byte ? rel_len : cnt_ff;
          end
        end
        ST_DRAIN: begin
          if (drain_end) begin
            state_ff <= ST_COLLECT;
          end
        end
        default: begin
          state_ff <= ST_COLLECT;
        end
      endcase
    end
  end

  // drain handshake
  assign frm_valid = (state_ff == ST_DRAIN);
  assign frm_last = frm_valid && (rd_ff == (flen_ff - 11'h001));
  assign frm_data = out_ff;
  assign drain_end = frm_valid && frm_ready && frm_last;
  assign nxt_rd = rd_ff + 11'h001;

  // read index within the frame
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ff <= '0;
    end else if (state_ff != ST_DRAIN || drain_end) begin
      rd_ff <= '0;
    end else if (frm_ready) begin
      rd_ff <= nxt_rd;
    end
  end

  // output byte register, prefetched from the buffer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_ff <= 8'h00;
    end else if (state_ff == ST_COLLECT && go_drain) begin
      out_ff <= (cnt_ff == '0) ? ser_data : buf_ff[0];
    end else if (frm_valid && frm_ready) begin
      out_ff <= buf_ff[nxt_rd[9:0]];
    end
  end

  // completed frame count
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frames_ff <= 16'h0000;
    end else if (drain_end) begin
      frames_ff <= frames_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_last_beat;
    frm_valid && frm_ready && frm_last;
  endsequence

  sequence s_back_idle;
    (state_ff == ST_COLLECT) && (cnt_ff == '0) && (rd_ff == '0);
  endsequence

  a_no_limit_hold: assert property (
    take && mark_en && !mark_hit && (post_ff == 2'h0) && (cfg.pkt_len == '0) &&
    (new_cnt != BUF_FULL) |=> (state_ff == ST_COLLECT) && (cnt_ff == $past(new_cnt)))
    else $error("bytes released without a cause");

  a_len_release: assert property (
    take && mark_en && !mark_hit && (post_ff == 2'h0) && (cfg.pkt_len != '0) &&
    (new_cnt == cfg.pkt_len) |=> (state_ff == ST_DRAIN) && (flen_ff == $past(cfg.pkt_len)))
    else $error("length limit did not release");

  a_pass_through: assert property (
    take && (cfg.delim1 == 8'h00) |=> (state_ff == ST_DRAIN) && (flen_ff == $past(new_cnt)))
    else $error("unmarked byte was held");

  a_pair_needed: assert property (
    take && mark_en && two && !prev_d1_ff && (post_ff == 2'h0) && (cfg.pkt_len == '0) &&
    (new_cnt != BUF_FULL) |=> (state_ff == ST_COLLECT))
    else $error("second marker alone released");

  a_full_release: assert property (
    take && !strip && (new_cnt == BUF_FULL) |=> (state_ff == ST_DRAIN) && (flen_ff == BUF_FULL))
    else $error("full buffer not released");

  a_plain_release: assert property (
    take && mark_hit && (cfg.proc_mode == PROC_PLAIN) |=>
    (state_ff == ST_DRAIN) && (flen_ff == $past(new_cnt)))
    else $error("plain marker did not release");

  a_post_wait: assert property (
    take && mark_hit && (cfg.proc_mode == PROC_PLUS2) && (cfg.pkt_len == '0) &&
    (cnt_ff < 11'h3fe) |=> (post_ff == 2'h2) && (state_ff == ST_COLLECT))
    else $error("plus two released early");

  a_post_fire: assert property (
    take && (post_ff == 2'h1) |=> (state_ff == ST_DRAIN) && (flen_ff == $past(new_cnt)))
    else $error("trailing byte did not release");

  a_strip_len: assert property (
    take && strip && (strip_len != '0) |=> (state_ff == ST_DRAIN) && (flen_ff == $past(strip_len)))
    else $error("stripped frame length wrong");

  a_idle_off: assert property (
    (cfg.force_ms == 16'h0000) || (cnt_ff == '0) |-> !idle_exp)
    else $error("idle timeout fired while disabled");

  a_idle_release: assert property (
    rel_idle |=> (state_ff == ST_DRAIN) && (flen_ff == $past(cnt_ff)))
    else $error("idle timeout did not release");

  a_sess_gate: assert property (
    !cfg.trigger_any || (cfg.inact_ms == 16'h0000) |-> !sess_exp)
    else $error("session timer active while off");

  a_drain_done: assert property (
    s_last_beat |=> s_back_idle)
    else $error("frame end did not empty the buffer");
endmodule // sbp_packer
`default_nettype wire

// ===== hw/sbp_pkg.sv
// constants and types shared by the serial byte packer
`default_nettype none
package sbp_pkg;
  // buffer geometry
  localparam int BUF_DEPTH = 1024;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] BUF_FULL = 11'h400;
  // register bus
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_PKT_LEN = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_DELIM = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_MODE = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_FORCE_MS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_INACT_MS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_FRAMES = 5'h18;
  // field positions
  localparam int DELIM2_LSB = 8;
  localparam int MODE_TRIG_BIT = 2;
  localparam int STAT_DRAIN_BIT = 16;
  localparam int STAT_CLOSE_BIT = 17;
  // reset values
  localparam logic [CNT_W-1:0] RST_PKT_LEN = 11'h000;
  localparam logic [15:0] RST_DELIM = 16'h0000;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [15:0] RST_FORCE_MS = 16'h0000;
  localparam logic [15:0] RST_INACT_MS = 16'h0000;
  // post-marker actions and packer states
  typedef enum logic [1:0] {PROC_PLAIN, PROC_PLUS1, PROC_PLUS2, PROC_STRIP} sbp_proc_type;
  typedef enum logic {ST_COLLECT, ST_DRAIN} sbp_state_type;
endpackage
`default_nettype wire

// ===== hw/sbp_cfg_if.sv
// configuration and status carried between register file and packer core
`timescale 1ns/1ps
`default_nettype none
interface sbp_cfg_if;
  import sbp_pkg::*;
  // configuration
  logic [CNT_W-1:0] pkt_len;
  logic [7:0] delim1;
  logic [7:0] delim2;
  sbp_proc_type proc_mode;
  logic trigger_any;
  logic [15:0] force_ms;
  logic [15:0] inact_ms;
  logic close_req;
  // status
  logic [CNT_W-1:0] buf_cnt;
  logic draining;
  logic [15:0] frames;
  logic close_set;
  modport regs (
    output pkt_len, delim1, delim2, proc_mode, trigger_any, force_ms, inact_ms, close_req,
    input buf_cnt, draining, frames, close_set
  );
  modport core (
    input pkt_len, delim1, delim2, proc_mode, trigger_any, force_ms, inact_ms, close_req,
    output buf_cnt, draining, frames, close_set
  );
endinterface
`default_nettype wire

// ===== hw/sbp_ms_timer.sv
// millisecond span timer with restart and one-shot expiry
`timescale 1ns/1ps
`default_nettype none
module sbp_ms_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [15:0] limit,
  // result
  output logic expire
);
  logic [15:0] cnt_ff;
  logic done_ff;
  logic hit;

  // expiry on the tick that completes the span; zero limit never fires
  assign hit = run && !restart && !done_ff && tick && (limit != 16'h0000) &&
               ((cnt_ff + 16'h0001) == limit);
  assign expire = hit;

  // tick count since last restart
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 16'h0000;
    end else if (!run || restart) begin
      cnt_ff <= 16'h0000;
    end else if (tick && !done_ff) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // one shot until restarted
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
    end else if (!run || restart) begin
      done_ff <= 1'b0;
    end else if (hit) begin
      done_ff <= 1'b1;
    end
  end
endmodule // sbp_ms_timer
`default_nettype wire

// ===== hw/sbp_regs.sv
// avalon-mm register file of the serial byte packer
`timescale 1ns/1ps
`default_nettype none
module sbp_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [sbp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // toward the core
  sbp_cfg_if.regs cfg
);
  import sbp_pkg::*;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [CNT_W-1:0] len_ff;
  logic [15:0] delim_ff;
  logic [2:0] mode_ff;
  logic [15:0] force_ff;
  logic [15:0] inact_ff;
  logic close_ff;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] rd_val;

  // one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign wr = avs_write && ack_ff;
  assign avs_readdata = rdata_ff;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // acknowledge and read capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      rdata_ff <= rd_val;
    end
  end

  // read decode, unmapped reads as zero
  always_comb begin
    rd_val = 32'h00000000;
    if (avs_address == OFF_PKT_LEN) begin
      rd_val[CNT_W-1:0] = len_ff;
    end else if (avs_address == OFF_DELIM) begin
      rd_val[15:0] = delim_ff;
    end else if (avs_address == OFF_MODE) begin
      rd_val[2:0] = mode_ff;
    end else if (avs_address == OFF_FORCE_MS) begin
      rd_val[15:0] = force_ff;
    end else if (avs_address == OFF_INACT_MS) begin
      rd_val[15:0] = inact_ff;
    end else if (avs_address == OFF_STATUS) begin
      rd_val[CNT_W-1:0] = cfg.buf_cnt;
      rd_val[STAT_DRAIN_BIT] = cfg.draining;
      rd_val[STAT_CLOSE_BIT] = close_ff;
    end else if (avs_address == OFF_FRAMES) begin
      rd_val[15:0] = cfg.frames;
    end
  end

  // configuration writes under byte enables
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_ff <= RST_PKT_LEN;
      delim_ff <= RST_DELIM;
      mode_ff <= RST_MODE;
      force_ff <= RST_FORCE_MS;
      inact_ff <= RST_INACT_MS;
    end else if (wr) begin
      if (avs_address == OFF_PKT_LEN) begin
        len_ff <= (len_ff & ~wmask[CNT_W-1:0]) | (avs_writedata[CNT_W-1:0] & wmask[CNT_W-1:0]);
      end else if (avs_address == OFF_DELIM) begin
        delim_ff <= (delim_ff & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
      end else if (avs_address == OFF_MODE) begin
        mode_ff <= (mode_ff & ~wmask[2:0]) | (avs_writedata[2:0] & wmask[2:0]);
      end else if (avs_address == OFF_FORCE_MS) begin
        force_ff <= (force_ff & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
      end else if (avs_address == OFF_INACT_MS) begin
        inact_ff <= (inact_ff & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
      end
    end
  end

  // sticky close request, write one clears, set wins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      close_ff <= 1'b0;
    end else if (cfg.close_set) begin
      close_ff <= 1'b1;
    end else if (wr && avs_address == OFF_STATUS && avs_byteenable[2] &&
                 avs_writedata[STAT_CLOSE_BIT]) begin
      close_ff <= 1'b0;
    end
  end

  // configuration toward the core
  assign cfg.pkt_len = len_ff;
  assign cfg.delim1 = delim_ff[7:0];
  assign cfg.delim2 = delim_ff[DELIM2_LSB+7:DELIM2_LSB];
  assign cfg.proc_mode = sbp_proc_type'(mode_ff[1:0]);
  assign cfg.trigger_any = mode_ff[MODE_TRIG_BIT];
  assign cfg.force_ms = force_ff;
  assign cfg.inact_ms = inact_ff;
  assign cfg.close_req = close_ff;
endmodule // sbp_regs
`default_nettype wire

// ===== bench/sbp_frm_sink.sv
// network-side frame sink model with optional stalling
`timescale 1ns/1ps
`default_nettype none
module sbp_frm_sink (
  // clock
  input wire logic ref_clk,
  // frame stream
  input wire logic frm_valid,
  input wire logic [7:0] frm_data,
  input wire logic frm_last,
  output logic frm_ready,
  // control
  input wire logic stall
);
  logic [7:0] got_q[$];
  int len_q[$];
  int cnt = 0;
  logic ph = 1'b0;
  // slow sink accepts every other cycle
  always @(posedge ref_clk) ph <= ~ph;
  assign frm_ready = ~stall | ph;
  // record bytes and frame lengths
  always @(posedge ref_clk) begin
    if (frm_valid && frm_ready) begin
      got_q.push_back(frm_data);
      cnt = cnt + 1;
      if (frm_last) begin
        len_q.push_back(cnt);
        cnt = 0;
      end
    end
  end
endmodule // sbp_frm_sink
`default_nettype wire

// ===== bench/test_sbp_packer.sv
// self-checking bench of the serial byte packer
`timescale 1ns/1ps
`default_nettype none
module test_sbp_packer;
  import sbp_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ser_valid = 1'b0;
  logic [7:0] ser_data = 8'h00;
  logic ser_ready;
  logic ser_tx_act = 1'b0;
  logic ms_tick = 1'b0;
  logic frm_valid, frm_last, frm_ready, session_close_req;
  logic [7:0] frm_data;
  logic stall = 1'b0;
  logic [31:0] rd;
  logic [7:0] exp_q[$];
  logic [ADDR_W-1:0] offs[6] = '{OFF_PKT_LEN, OFF_DELIM, OFF_MODE, OFF_FORCE_MS,
    OFF_INACT_MS, 5'h1c};
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int nfrm = 0;
  // clock
  always #2 ref_clk = ~ref_clk;
  sbp_packer sbp_packer_inst (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .ser_valid, .ser_data,
    .ser_ready, .ser_tx_act, .ms_tick, .frm_valid, .frm_data, .frm_last, .frm_ready,
    .session_close_req);
  sbp_frm_sink sbp_frm_sink_inst (.ref_clk, .frm_valid, .frm_data, .frm_last, .frm_ready,
    .stall);
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= ~we;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // n copies of a serial byte, each offered only while the packer collects
  task automatic put_n(input logic [7:0] d, input int n, input bit keep);
    repeat (n) begin
      do @(negedge ref_clk); while (ser_ready !== 1'b1);
      @(posedge ref_clk);
      ser_valid <= 1'b1;
      ser_data <= d;
      @(posedge ref_clk);
      ser_valid <= 1'b0;
      if (keep) exp_q.push_back(d);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ms_tick <= 1'b1;
      @(posedge ref_clk);
      ms_tick <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
  endtask
  // wait for one frame and compare its length and bytes
  task automatic frame(input int n);
    int k;
    k = 0;
    while (sbp_frm_sink_inst.len_q.size() == 0 && k < 4000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(sbp_frm_sink_inst.len_q.size(), 1);
    if (sbp_frm_sink_inst.len_q.size() != 0) chk(sbp_frm_sink_inst.len_q.pop_front(), n);
    while (exp_q.size() != 0 && sbp_frm_sink_inst.got_q.size() != 0)
      chk(sbp_frm_sink_inst.got_q.pop_front(), exp_q.pop_front());
    chk(exp_q.size() + sbp_frm_sink_inst.got_q.size(), 0);
    nfrm++;
  endtask
  // cycle ceiling against a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("unexpected at %0t: cycle limit reached", $time);
      give_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b1, OFF_FRAMES, 32'h5);
    bus(1'b0, OFF_FRAMES, 32'h0);
    chk(rd, 32'h0);
    put_n(8'h31, 1, 1);
    frame(1);
    bus(1'b1, OFF_DELIM, 32'h0d);
    put_n(8'h41, 2, 1);
    put_n(8'h0d, 1, 1);
    frame(3);
    for (int m = 1; m < 3; m++) begin
      bus(1'b1, OFF_MODE, m);
      put_n(8'h0d, 1, 1);
      put_n(8'h43, m, 1);
      frame(m + 1);
    end
    bus(1'b1, OFF_MODE, 32'h3);
    put_n(8'h44, 2, 1);
    put_n(8'h0d, 1, 0);
    frame(2);
    bus(1'b1, OFF_MODE, 32'h0);
    bus(1'b1, OFF_DELIM, 32'h0a0d);
    put_n(8'h0d, 1, 1);
    put_n(8'h45, 1, 1);
    put_n(8'h0d, 1, 1);
    put_n(8'h0a, 1, 1);
    frame(4);
    bus(1'b1, OFF_PKT_LEN, 32'h3);
    put_n(8'h46, 3, 1);
    frame(3);
    bus(1'b1, OFF_PKT_LEN, 32'h0);
    bus(1'b1, OFF_FORCE_MS, 32'h3);
    put_n(8'h47, 2, 1);
    tick(2);
    chk(sbp_frm_sink_inst.len_q.size(), 0);
    tick(1);
    frame(2);
    tick(4);
    chk(sbp_frm_sink_inst.len_q.size(), 0);
    bus(1'b1, OFF_FORCE_MS, 32'h0);
    stall <= 1'b1;
    put_n(8'h48, 1024, 1);
    frame(1024);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd[10:0], 11'h000);
    bus(1'b0, OFF_FRAMES, 32'h0);
    chk(rd[15:0], nfrm[15:0]);
    bus(1'b1, OFF_INACT_MS, 32'h2);
    tick(4);
    chk(session_close_req, 1'b0);
    bus(1'b1, OFF_MODE, 32'h4);
    ser_tx_act <= 1'b1;
    @(posedge ref_clk);
    ser_tx_act <= 1'b0;
    tick(1);
    chk(session_close_req, 1'b0);
    tick(1);
    chk(session_close_req, 1'b1);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd[STAT_CLOSE_BIT], 1'b1);
    bus(1'b1, OFF_STATUS, 32'h20000);
    // the clear lands on the completion edge, look one edge later
    @(posedge ref_clk);
    chk(session_close_req, 1'b0);
    give_verdict();
  end
endmodule // test_sbp_packer
`default_nettype wire
